// ==== rtl/awc_pkg.sv ====
package awc_pkg;
    // register word offsets (printed offsets not multiples of four: index, byte = 4*index)
    localparam logic [7:0]  AWC_IDX_LT_LOW   = 8'hc5;
    localparam logic [7:0]  AWC_IDX_LT_HIGH  = 8'hc6;
    localparam logic [7:0]  AWC_IDX_GT_LOW   = 8'hc3;
    localparam logic [7:0]  AWC_IDX_GT_HIGH  = 8'hc4;
    localparam logic [7:0]  AWC_IDX_IN_SEL   = 8'hbb;
    localparam logic [7:0]  AWC_IDX_RES_LOW  = 8'hbd;
    localparam logic [7:0]  AWC_IDX_RES_HIGH = 8'hbe;
    localparam logic [7:0]  AWC_IDX_STATUS   = 8'hc0;
    localparam logic [7:0]  AWC_IDX_MASK     = 8'hc1;
    localparam logic [7:0]  AWC_IDX_REF_CTL  = 8'hd2;
    // reset values and reference control write mask
    localparam logic [7:0]  AWC_RST_LT       = 8'h00;
    localparam logic [7:0]  AWC_RST_GT       = 8'hff;
    localparam logic [4:0]  AWC_RST_IN_SEL   = 5'h1f;
    localparam logic [7:0]  AWC_RST_REF_CTL  = 8'h08;
    localparam logic [7:0]  AWC_REF_CTL_MASK = 8'h3e;
    // field width and positions
    localparam int          AWC_SEL_W        = 5;
    localparam int          AWC_BIT_WINDOW   = 0;
    localparam int          AWC_BIT_TEMP_SENSOR_ENABLE    = 2;
    // input select codes
    localparam logic [4:0]  AWC_CODE_P1_0    = 5'h08;
    localparam logic [4:0]  AWC_CODE_P1_4    = 5'h0c;
    localparam logic [4:0]  AWC_CODE_TEMP    = 5'h10;
    localparam logic [4:0]  AWC_CODE_REG     = 5'h11;
    localparam logic [4:0]  AWC_CODE_VDD     = 5'h12;
    localparam logic [4:0]  AWC_CODE_GND     = 5'h13;
    // input route kinds
    typedef enum logic [2:0] {
        AWC_SRC_NONE, AWC_SRC_PIN, AWC_SRC_TEMP, AWC_SRC_REG, AWC_SRC_VDD, AWC_SRC_GND
    } awc_src_e;
endpackage

// ==== rtl/awc_window_cmp.sv ====
`timescale 1ns/10ps
module awc_window_cmp
    import awc_pkg::*;
#(
    parameter int W = 16
) (
    // limits and sample
    input  wire logic [W-1:0] result,
    input  wire logic [W-1:0] gt_limit,
    input  wire logic [W-1:0] lt_limit,
    // decision
    output logic              hit
);
    logic above;
    logic below;
    assign above = result > gt_limit;
    assign below = result < lt_limit;
    // mode follows the limit order alone
    always_comb begin //RULE5
        if (lt_limit > gt_limit) begin
            hit = above && below; //RULE3
        end else begin
            hit = below || above; //RULE4
        end
    end
endmodule

// ==== rtl/awc_input_mux.sv ====
`timescale 1ns/10ps
module awc_input_mux
    import awc_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    // code in
    input  wire logic [4:0] code,
    // route out
    output awc_src_e        src,
    output logic [15:0]     pin_onehot
);
    always_comb begin
        pin_onehot = 16'h0000;
        src        = AWC_SRC_NONE;
        if (code < AWC_CODE_P1_0) begin
            src = AWC_SRC_PIN; //RULE8
            pin_onehot[code[3:0]] = 1'b1;
        end else if (code < AWC_CODE_TEMP) begin
            if (LARGE_PKG || code < AWC_CODE_P1_4) begin //RULE9
                src = AWC_SRC_PIN;
                pin_onehot[code[3:0]] = 1'b1;
            end
        end else begin
            unique case (code)
                AWC_CODE_TEMP: src = AWC_SRC_TEMP; //RULE10
                AWC_CODE_REG:  src = AWC_SRC_REG;
                AWC_CODE_VDD:  src = AWC_SRC_VDD;
                AWC_CODE_GND:  src = AWC_SRC_GND;
                default:       src = AWC_SRC_NONE; //RULE16
            endcase
        end
    end
endmodule

// ==== rtl/awc_top.sv ====
// Behaviour
// [RULE1] lower limit high byte, RW, reset zero
// [RULE2] lower limit low byte, RW, reset zero
// [RULE3] inside mode: gt < result < lt
// [RULE4] outside mode: result below or above bounds
// [RULE5] mode set only by limit ordering
// [RULE6] compare formatted result words continuously
// [RULE7] result is 10-bit unsigned value
// [RULE8] codes 0-7 select port 0 pins
// [RULE9] codes 8-15 port 1; small package reserves 12-15
// [RULE10] temp, regulator, supply, ground; higher none
// [RULE11] select upper three bits read zero
// [RULE12] software clears pin digital input mode
// [RULE13] software sets pin crossbar skip
// [RULE14] software enables temp sensor before use
// [RULE15] window flag set on hit, sticky
// [RULE16] reserved codes drive nothing, no error
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
module awc_top
    import awc_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // converter core
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_code,
    input  wire logic        left_justify,
    // analog routing
    output logic [15:0]      pin_route_en,
    output awc_src_e         analog_input_mux,
    output logic             temp_sensor_enable,
    // interrupt
    output logic             irq
);
    logic [7:0]  lt_low_q, lt_high_q, gt_low_q, gt_high_q;
    logic [4:0]  in_sel_q;
    logic [15:0] result_q;
    logic [7:0]  ref_ctl_q;
    logic        status_q, mask_q;
    logic        wr_en, rd_en, hit, ev_win;
    logic [7:0]  idx;
    logic        mapped;
    logic [31:0] rd_d;
    logic [15:0] res_fmt, pin_d;
    awc_src_e    src_d;

    assign idx   = paddr[9:2];
    assign wr_en = clk_en && psel && penable && pwrite && pready && mapped && pstrb[0];
    assign rd_en = clk_en && psel && penable && !pwrite && !pready;

    always_comb begin
        mapped = 1'b1;
        rd_d   = 32'h0000_0000;
        unique case (idx)
            AWC_IDX_LT_LOW:   rd_d[7:0] = lt_low_q;
            AWC_IDX_LT_HIGH:  rd_d[7:0] = lt_high_q;
            AWC_IDX_GT_LOW:   rd_d[7:0] = gt_low_q;
            AWC_IDX_GT_HIGH:  rd_d[7:0] = gt_high_q;
            AWC_IDX_IN_SEL:   rd_d[7:0] = {3'b000, in_sel_q}; //RULE11
            AWC_IDX_RES_LOW:  rd_d[7:0] = result_q[7:0];
            AWC_IDX_RES_HIGH: rd_d[7:0] = result_q[15:8];
            AWC_IDX_STATUS:   rd_d[0]   = status_q;
            AWC_IDX_MASK:     rd_d[0]   = mask_q;
            AWC_IDX_REF_CTL:  rd_d[7:0] = ref_ctl_q;
            default:          mapped    = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00) begin
            mapped = 1'b0;
        end
    end

    // one wait state: answer in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (rd_en) begin
                prdata <= mapped ? rd_d : 32'h0000_0000;
            end
        end
    end

    // lower limit bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lt_low_q  <= AWC_RST_LT; //RULE2
            lt_high_q <= AWC_RST_LT; //RULE1
        end else if (wr_en) begin
            if (idx == AWC_IDX_LT_LOW) begin
                lt_low_q <= pwdata[7:0]; //RULE2
            end
            if (idx == AWC_IDX_LT_HIGH) begin
                lt_high_q <= pwdata[7:0]; //RULE1
            end
        end
    end

    // upper limit bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gt_low_q  <= AWC_RST_GT;
            gt_high_q <= AWC_RST_GT;
        end else if (wr_en) begin
            if (idx == AWC_IDX_GT_LOW) begin
                gt_low_q <= pwdata[7:0];
            end
            if (idx == AWC_IDX_GT_HIGH) begin
                gt_high_q <= pwdata[7:0];
            end
        end
    end

    // input select and reference control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_sel_q  <= AWC_RST_IN_SEL;
            ref_ctl_q <= AWC_RST_REF_CTL;
        end else if (wr_en) begin
            if (idx == AWC_IDX_IN_SEL) begin
                in_sel_q <= pwdata[AWC_SEL_W-1:0]; //RULE11
            end
            if (idx == AWC_IDX_REF_CTL) begin
                ref_ctl_q <= pwdata[7:0] & AWC_REF_CTL_MASK;
            end
        end
    end

    // result formatting of the 10-bit unsigned code
    assign res_fmt = left_justify ? {conv_code, 6'b00_0000}
                                  : {6'b00_0000, conv_code}; //RULE7

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 16'h0000;
        end else if (clk_en && conv_done) begin
            result_q <= res_fmt;
        end
    end

    // compare on the fresh formatted word, same justification as limits
    awc_window_cmp #(
        .W (16)
    ) u_cmp (
        .result   (res_fmt), //RULE6
        .gt_limit ({gt_high_q, gt_low_q}),
        .lt_limit ({lt_high_q, lt_low_q}),
        .hit      (hit)
    );

    assign ev_win = conv_done && hit;

    // sticky flag, set beats write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 1'b0;
        end else if (clk_en) begin
            if (ev_win) begin
                status_q <= 1'b1; //RULE15
            end else if (wr_en && idx == AWC_IDX_STATUS && pwdata[AWC_BIT_WINDOW]) begin
                status_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 1'b0;
            irq    <= 1'b0;
        end else if (clk_en) begin
            if (wr_en && idx == AWC_IDX_MASK) begin
                mask_q <= pwdata[AWC_BIT_WINDOW];
            end
            irq <= status_q && mask_q;
        end
    end

    awc_input_mux #(
        .LARGE_PKG (LARGE_PKG)
    ) u_mux (
        .code       (in_sel_q),
        .src        (src_d),
        .pin_onehot (pin_d)
    );

    // registered analog routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_route_en       <= 16'h0000;
            analog_input_mux   <= AWC_SRC_NONE;
            temp_sensor_enable <= 1'b0;
        end else if (clk_en) begin
            pin_route_en       <= pin_d; //RULE16
            analog_input_mux   <= src_d;
            temp_sensor_enable <= ref_ctl_q[AWC_BIT_TEMP_SENSOR_ENABLE];
        end
    end

    // checks
    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        clk_en && ev_win |=> status_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("window flag not set"); //RULE15

    property p_flag_hold;
        @(posedge pclk) disable iff (!presetn)
        status_q && !(wr_en && idx == AWC_IDX_STATUS) |=> status_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("window flag lost"); //RULE15

    property p_inside;
        @(posedge pclk) disable iff (!presetn)
        ({lt_high_q, lt_low_q} > {gt_high_q, gt_low_q}) && hit
            |-> res_fmt > {gt_high_q, gt_low_q} && res_fmt < {lt_high_q, lt_low_q};
    endproperty
    a_inside: assert property (p_inside) else $error("inside compare wrong"); //RULE3

    property p_outside;
        @(posedge pclk) disable iff (!presetn)
        ({lt_high_q, lt_low_q} <= {gt_high_q, gt_low_q})
            |-> hit == (res_fmt < {lt_high_q, lt_low_q} || res_fmt > {gt_high_q, gt_low_q});
    endproperty
    a_outside: assert property (p_outside) else $error("outside compare wrong"); //RULE4

    property p_sel_zero;
        @(posedge pclk) disable iff (!presetn)
        rd_en && idx == AWC_IDX_IN_SEL |=> prdata[7:5] == 3'b000;
    endproperty
    a_sel_zero: assert property (p_sel_zero) else $error("select upper bits set"); //RULE11

    property p_lt_write;
        @(posedge pclk) disable iff (!presetn)
        wr_en && idx == AWC_IDX_LT_HIGH |=> lt_high_q == $past(pwdata[7:0]);
    endproperty
    a_lt_write: assert property (p_lt_write) else $error("limit high not written"); //RULE1

    property p_lt_low_write;
        @(posedge pclk) disable iff (!presetn)
        wr_en && idx == AWC_IDX_LT_LOW |=> lt_low_q == $past(pwdata[7:0]);
    endproperty
    a_lt_low_write: assert property (p_lt_low_write) else $error("limit low not written"); //RULE2

    property p_no_drive;
        @(posedge pclk) disable iff (!presetn)
        clk_en && in_sel_q >= AWC_CODE_TEMP |=> pin_route_en == 16'h0000;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("pin driven on non-pin code"); //RULE16

    property p_pin_route;
        @(posedge pclk) disable iff (!presetn)
        clk_en && in_sel_q < AWC_CODE_P1_0 |=> $onehot(pin_route_en);
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("port 0 pin not routed"); //RULE8

    property p_sel_write;
        @(posedge pclk) disable iff (!presetn)
        wr_en && idx == AWC_IDX_IN_SEL |=> in_sel_q == $past(pwdata[4:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select not written"); //RULE11

    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        wr_en && idx == AWC_IDX_STATUS && pwdata[AWC_BIT_WINDOW] && !ev_win |=> !status_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("window flag not cleared"); //RULE15

    property p_irq_follow;
        @(posedge pclk) disable iff (!presetn)
        clk_en && status_q && mask_q |=> irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("interrupt not raised");

    // bus answer in two steps
    sequence s_access_start;
        clk_en && psel && penable && !pready;
    endsequence

    sequence s_answer_drop;
        clk_en && pready;
    endsequence

    property p_answer;
        @(posedge pclk) disable iff (!presetn)
        s_access_start |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer missing");

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        s_answer_drop |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("bus answer too long");
endmodule

// ==== dv/awc_core_model.sv ====
`timescale 1ns/10ps
module awc_core_model (
    // control
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic       slow,
    input  wire logic [9:0] sample,
    // result
    output logic            conv_done,
    output logic [9:0]      conv_code
);
    logic [3:0] cnt_q;
    logic [9:0] hold_q;
    // result only valid with done; otherwise a toggling pattern
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 4'h0;
            hold_q    <= 10'h000;
            conv_done <= 1'b0;
            conv_code <= 10'h155;
        end else begin
            conv_done <= 1'b0;
            conv_code <= ~conv_code;
            if (start) begin
                cnt_q  <= slow ? 4'h6 : 4'h1;
                hold_q <= sample;
            end else if (cnt_q == 4'h1) begin
                cnt_q     <= 4'h0;
                conv_done <= 1'b1;
                conv_code <= hold_q;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

// ==== dv/awc_top_test.sv ====
`timescale 1ns/10ps
module awc_top_test;
    import awc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rnd;
    logic        pready, pslverr, conv_done, left_justify = 0, go = 0, slow = 0;
    logic        temp_sensor_enable, irq, msk;
    logic [9:0]  conv_code, smp = 0;
    logic [15:0] pin_route_en, e_pin, pin_route_en_s;
    awc_src_e    analog_input_mux, e_src, analog_input_mux_s;
    logic [32:0] notes[$];
    int          fail_count = 0, comparisons = 0, c;

    always #12.5 pclk = ~pclk;

    awc_top dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .conv_code(conv_code), .left_justify(left_justify),
        .pin_route_en(pin_route_en), .analog_input_mux(analog_input_mux),
        .temp_sensor_enable(temp_sensor_enable), .irq(irq));
    awc_core_model core (.pclk(pclk), .presetn(presetn), .start(go), .slow(slow),
        .sample(smp), .conv_done(conv_done), .conv_code(conv_code));
    // small package copy, same bus traffic
    awc_top #(.LARGE_PKG(1'b0)) dut_small (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(), .pready(), .pslverr(),
        .conv_done(conv_done), .conv_code(conv_code), .left_justify(left_justify),
        .pin_route_en(pin_route_en_s), .analog_input_mux(analog_input_mux_s),
        .temp_sensor_enable(), .irq());

    task cmp(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask
    task rd(input logic [7:0] idx, input logic [32:0] exp);
        notes.push_back(exp);
        apb(1'b0, idx, 32'h0000_0000);
    endtask
    // read results are matched to the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && notes.size() > 0)
            cmp({pslverr, prdata}, notes.pop_front());
    end
    task win(input logic [15:0] gt, lt, input logic [9:0] cd, input logic lj, hit);
        int i;
        wr(AWC_IDX_GT_LOW, {24'h0, gt[7:0]});
        wr(AWC_IDX_GT_HIGH, {24'h0, gt[15:8]});
        wr(AWC_IDX_LT_LOW, {24'h0, lt[7:0]});
        wr(AWC_IDX_LT_HIGH, {24'h0, lt[15:8]});
        left_justify <= lj;
        smp  <= cd;
        slow <= ~slow;
        go   <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        for (i = 0; i < 20 && conv_done !== 1'b1; i++) @(posedge pclk);
        repeat (3) @(posedge pclk);
        rd(AWC_IDX_STATUS, {32'h0, hit});
        repeat (4) @(posedge pclk);
        cmp({32'h0, irq}, {32'h0, hit & msk});
        rd(AWC_IDX_STATUS, {32'h0, hit});
        wr(AWC_IDX_STATUS, 32'h0000_0001);
        rd(AWC_IDX_STATUS, 33'h0);
    endtask

    initial begin
        #(20000 * 25);
        fail_count++;
        stop_test();
    end
    initial begin
        rnd = $urandom(59);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(AWC_IDX_LT_LOW, 33'h0);
        rd(AWC_IDX_LT_HIGH, 33'h0);
        rd(AWC_IDX_IN_SEL, {28'h0, AWC_RST_IN_SEL});
        rd(8'h80, {1'b1, 32'h0});
        $display("test reset done");
        rnd = $urandom;
        wr(AWC_IDX_LT_LOW, rnd);
        wr(AWC_IDX_LT_HIGH, ~rnd);
        rd(AWC_IDX_LT_LOW, {25'h0, rnd[7:0]});
        rd(AWC_IDX_LT_HIGH, {25'h0, ~rnd[7:0]});
        wr(AWC_IDX_IN_SEL, 32'h0000_00ff);
        rd(AWC_IDX_IN_SEL, 33'h0_0000_001f);
        $display("test registers done");
        for (c = 0; c < 32; c++) begin
            wr(AWC_IDX_IN_SEL, c);
            repeat (2) @(posedge pclk);
            e_pin = (c < 16) ? (16'h0001 << c) : 16'h0000;
            e_src = (c < 16) ? AWC_SRC_PIN : (c == 16) ? AWC_SRC_TEMP :
                    (c == 17) ? AWC_SRC_REG : (c == 18) ? AWC_SRC_VDD :
                    (c == 19) ? AWC_SRC_GND : AWC_SRC_NONE;
            cmp({14'h0, pin_route_en, analog_input_mux}, {14'h0, e_pin, e_src});
            cmp({14'h0, pin_route_en_s, analog_input_mux_s},
                (c >= 12 && c < 16) ? 33'h0 : {14'h0, e_pin, e_src});
        end
        wr(AWC_IDX_REF_CTL, 32'h0000_000c);
        repeat (2) @(posedge pclk);
        cmp({32'h0, temp_sensor_enable}, 33'h1);
        $display("test input select done");
        msk = 1'b1;
        wr(AWC_IDX_MASK, 32'h0000_0001);
        win(16'h0040, 16'h0080, 10'h040, 1'b0, 1'b0);
        win(16'h0040, 16'h0080, 10'h041, 1'b0, 1'b1);
        win(16'h0040, 16'h0080, 10'h07f, 1'b0, 1'b1);
        win(16'h0040, 16'h0080, 10'h080, 1'b0, 1'b0);
        win(16'h0040, 16'h0080, 10'h041 + 10'($urandom % 63), 1'b0, 1'b1);
        win(16'h0080, 16'h0040, 10'h03f, 1'b0, 1'b1);
        win(16'h0080, 16'h0040, 10'h040, 1'b0, 1'b0);
        win(16'h0080, 16'h0040, 10'h080, 1'b0, 1'b0);
        win(16'h0080, 16'h0040, 10'h3ff, 1'b0, 1'b1);
        win(16'h1000, 16'h2000, 10'h041, 1'b1, 1'b1);
        win(16'h1000, 16'h2000, 10'h040, 1'b1, 1'b0);
        msk = 1'b0;
        wr(AWC_IDX_MASK, 32'h0000_0000);
        win(16'h0080, 16'h0040, 10'h000, 1'b0, 1'b1);
        $display("test window done");
        stop_test();
    end
endmodule
